// File: rtl/csr_core_regs.sv
`timescale 1ns/10ps
module csr_core_regs #(
    parameter int PC_W    = csr_pkg::CSR_PC_W,
    parameter int STACK_D = csr_pkg::CSR_STACK_D
) (
    input  wire logic               core_clk_in,
    input  wire logic               reset_in,
    input  wire logic               power_on_in,
    input  wire logic               count_pin_in,
    input  wire logic               count_edge_select_in,
    input  wire logic               count_source_pin_in,
    input  wire logic               prescaler_wr_in,
    input  wire logic [3:0]         prescaler_sel_in,
    input  wire csr_pkg::csr_pcop_t pc_op_in,
    input  wire logic [PC_W-1:0]    pc_target_in,
    input  wire csr_pkg::csr_dreq_t dreq_in,
    input  wire csr_pkg::csr_sev_t  sev_in,
    output logic [PC_W-1:0]         pc_out,
    output logic [7:0]              rdata_out,
    output logic                    rvalid_out,
    output logic                    instr_strobe_out,
    output logic                    special_sel_out,
    output logic [5:0]              special_addr_out,
    output logic                    special_bank_out,
    output logic                    io_segment_out,
    output logic [7:0]              status_out,
    output logic [7:0]              prescaler_out,
    output logic [7:0]              event_counter_out
);
    import csr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage and local signals.
    logic [PC_W-1:0] pc_r;                       // Program counter.
    logic [PC_W-1:0] stack_r [STACK_D];          // Return stack entries.
    logic [2:0]      sp_r;                       // Next free stack slot.
    logic [7:0]      status_r;                   // Core status flags.
    logic [7:0]      rsp_r;                      // RAM select pointer.
    logic [7:0]      cnt_r;                      // Event counter value.
    logic [7:0]      pre_r;                      // Prescaler state.
    logic            phase_r;                    // Oscillator phase in cycle.
    logic            second_r;                   // Second cycle of long op.
    logic            pin_s1_r;                   // Synchroniser, first stage.
    logic            pin_s2_r;                   // Synchroniser, second stage.
    logic            pin_d_r;                    // Previous synced level.
    logic            instr_en;                   // One pulse per instruction.
    logic            pin_edge;                   // Selected pin edge seen.
    logic [5:0]      eff_addr;                   // Address after indirection.
    logic            ram_hit;                    // Access targets the RAM.
    logic [6:0]      ram_addr;                   // Physical RAM index.
    logic [7:0]      ram_rdata;                  // RAM read data.
    logic [7:0]      reg_rdata_nxt;              // Core register read mux.
    logic            rd_ram_r;                   // Read answered from RAM.
    logic [7:0]      reg_rdata_r;                // Registered register read.
    logic            rd_pend_r;                  // Read in flight.
    logic            long_op;                    // Long jump or long call.

    // Map a data address and bank bit onto the physical RAM index.
    function automatic logic [6:0] ram_index(input logic [5:0] a, input logic bank);
        logic [6:0] idx;
        idx = 7'h00;
        if (a <= CSR_ADR_COMMON_HI) begin
            idx = {3'h0, a[3:0]};
        end else begin
            idx = 7'h10 + {1'b0, bank, a[4:0]};
        end
        return idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Instruction cycle timing: two oscillator clocks per cycle.
    // A long operation stretches the cycle so the PC advances once in two.
    assign long_op  = (pc_op_in == CSR_PC_LONG_JUMP) || (pc_op_in == CSR_PC_LONG_CALL);
    assign instr_en = phase_r && !(long_op && !second_r);

    // Phase toggles every clock; the long-op marker holds one extra cycle.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            phase_r  <= 1'b0;
            second_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
            if (phase_r) begin
                second_r <= long_op && !second_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Effective address: the indirect port holds nothing and redirects.
    assign eff_addr = (dreq_in.addr == CSR_ADR_INDIRECT) ? rsp_r[5:0]
                                                        : dreq_in.addr;
    assign ram_hit  = eff_addr >= CSR_ADR_COMMON_LO;
    assign ram_addr = ram_index(eff_addr, rsp_r[CSR_RSP_BANK]);

    // Data store for common and banked general registers.
    csr_ram #(
        .DEPTH (CSR_RAM_WORDS),
        .AW    (7)
    ) u_ram (
        .core_clk_in (core_clk_in),
        .we_in       (dreq_in.wr && ram_hit),
        .addr_in     (ram_addr),
        .wdata_in    (dreq_in.wdata),
        .rdata_out   (ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Input synchroniser for the external count pin.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_d_r  <= 1'b0;
        end else begin
            pin_s1_r <= count_pin_in;
            pin_s2_r <= pin_s1_r;
            pin_d_r  <= pin_s2_r;
        end
    end

    // Edge select 0 counts rising edges, 1 counts falling edges.
    assign pin_edge = count_edge_select_in ? (pin_d_r && !pin_s2_r)
                                           : (!pin_d_r && pin_s2_r);

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler: free count of source ticks, cleared on the listed writes.
    // Its divided output is left to the select logic outside this block.
    always_ff @(posedge core_clk_in) begin
        if (reset_in || power_on_in) begin
            pre_r <= CSR_PRE_RST;
        end else if (prescaler_wr_in ||
                     (dreq_in.wr && eff_addr == CSR_ADR_COUNTER)) begin
            pre_r <= CSR_PRE_RST;
        end else if (count_source_pin_in ? pin_edge : instr_en) begin
            pre_r <= pre_r + 8'h01;
        end
    end

    // Event counter: a software write wins over a tick in the same cycle.
    always_ff @(posedge core_clk_in) begin
        if (reset_in || power_on_in) begin
            cnt_r <= CSR_CNT_RST;
        end else if (dreq_in.wr && eff_addr == CSR_ADR_COUNTER) begin
            cnt_r <= dreq_in.wdata;
        end else if (count_source_pin_in ? pin_edge : instr_en) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and return stack. Data writes to the PC low register
    // take effect at the instruction boundary in place of the step.
    always_ff @(posedge core_clk_in) begin
        if (reset_in || power_on_in) begin
            pc_r <= CSR_PC_RST;
            sp_r <= 3'h0;
        end else if (instr_en) begin
            if (dreq_in.wr && eff_addr == CSR_ADR_PC_LOW) begin
                if (dreq_in.add_pc) begin
                    pc_r <= pc_r + {3'h0, dreq_in.wdata};
                end else begin
                    pc_r <= {pc_r[PC_W-1:8], dreq_in.wdata};
                end
            end else begin
                case (pc_op_in)
                    CSR_PC_STEP: begin
                        pc_r <= pc_r + 11'h001;
                    end
                    CSR_PC_HOLD: begin
                        pc_r <= pc_r;
                    end
                    CSR_PC_SJMP: begin
                        pc_r <= {pc_r[PC_W-1:CSR_PAGE_W],
                                 pc_target_in[CSR_PAGE_W-1:0]};
                    end
                    CSR_PC_SCALL: begin
                        stack_r[sp_r] <= pc_r + 11'h001;
                        sp_r          <= sp_r + 3'h1;
                        pc_r <= {pc_r[PC_W-1:CSR_PAGE_W],
                                 pc_target_in[CSR_PAGE_W-1:0]};
                    end
                    CSR_PC_LONG_JUMP: begin
                        pc_r <= pc_target_in;
                    end
                    CSR_PC_LONG_CALL: begin
                        stack_r[sp_r] <= pc_r + 11'h001;
                        sp_r          <= sp_r + 3'h1;
                        pc_r          <= pc_target_in;
                    end
                    CSR_PC_RET: begin
                        pc_r <= stack_r[sp_r - 3'h1];
                        sp_r <= sp_r - 3'h1;
                    end
                    default: begin
                        pc_r <= pc_r;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status register. Hardware events win over a software write.
    always_ff @(posedge core_clk_in) begin
        if (power_on_in) begin
            status_r <= CSR_STATUS_RST;
        end else if (reset_in) begin
            status_r[CSR_ST_RST] <= sev_in.wake_event;
        end else begin
            if (dreq_in.wr && eff_addr == CSR_ADR_STATUS) begin
                status_r[CSR_ST_IO_SEGMENT_SELECT] <= dreq_in.wdata[CSR_ST_IO_SEGMENT_SELECT];
                status_r[CSR_ST_Z]    <= dreq_in.wdata[CSR_ST_Z];
                status_r[CSR_ST_DC]   <= dreq_in.wdata[CSR_ST_DC];
                status_r[CSR_ST_C]    <= dreq_in.wdata[CSR_ST_C];
            end
            if (sev_in.flag_wr) begin
                status_r[CSR_ST_Z]  <= sev_in.z;
                status_r[CSR_ST_DC] <= sev_in.dc;
                status_r[CSR_ST_C]  <= sev_in.c;
            end
            if (sev_in.wdt_timeout) begin
                status_r[CSR_ST_T] <= 1'b0;
            end else if (sev_in.sleep_instr || sev_in.watchdog_clear_instruction_instr) begin
                status_r[CSR_ST_T] <= 1'b1;
            end
            if (sev_in.watchdog_clear_instruction_instr) begin
                status_r[CSR_ST_P] <= 1'b1;
            end else if (sev_in.sleep_instr) begin
                status_r[CSR_ST_P] <= 1'b0;
            end
            status_r[5] <= 1'b0;
        end
    end

    // RAM select pointer, plain read/write.
    always_ff @(posedge core_clk_in) begin
        if (reset_in || power_on_in) begin
            rsp_r <= CSR_RSP_RST;
        end else if (dreq_in.wr && eff_addr == CSR_ADR_RSP) begin
            rsp_r <= dreq_in.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: core registers muxed, RAM data already registered.
    always_comb begin
        reg_rdata_nxt = 8'h00;
        case (eff_addr)
            CSR_ADR_INDIRECT: reg_rdata_nxt = 8'h00;
            CSR_ADR_COUNTER:  reg_rdata_nxt = cnt_r;
            CSR_ADR_PC_LOW:   reg_rdata_nxt = pc_r[7:0];
            CSR_ADR_STATUS:   reg_rdata_nxt = status_r & 8'hdf;
            CSR_ADR_RSP:      reg_rdata_nxt = rsp_r;
            default:          reg_rdata_nxt = 8'h00;
        endcase
    end

    // Register the read answer one cycle after the request.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rd_pend_r   <= 1'b0;
            rd_ram_r    <= 1'b0;
            reg_rdata_r <= 8'h00;
        end else begin
            rd_pend_r   <= dreq_in.rd;
            rd_ram_r    <= ram_hit;
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    // Output registers; the RAM word is picked a cycle after its read.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rdata_out         <= 8'h00;
            rvalid_out        <= 1'b0;
            instr_strobe_out  <= 1'b0;
            special_sel_out   <= 1'b0;
            special_addr_out  <= 6'h00;
            special_bank_out  <= 1'b0;
            io_segment_out    <= 1'b0;
        end else begin
            // Read data stands until the next read is answered.
            if (rd_pend_r) begin
                rdata_out <= rd_ram_r ? ram_rdata : reg_rdata_r;
            end
            rvalid_out       <= rd_pend_r;
            instr_strobe_out <= instr_en;
            special_sel_out  <= (dreq_in.rd || dreq_in.wr) &&
                                eff_addr >= CSR_ADR_SPECIAL_LO &&
                                eff_addr <= CSR_ADR_SPECIAL_HI;
            special_addr_out <= eff_addr;
            special_bank_out <= rsp_r[CSR_RSP_SPECIAL_BANK_SELECT];
            io_segment_out   <= status_r[CSR_ST_IO_SEGMENT_SELECT];
        end
    end

    // Direct views of architectural state.
    assign pc_out            = pc_r;
    assign status_out        = status_r;
    assign prescaler_out     = pre_r;
    assign event_counter_out = cnt_r;
endmodule

// File: rtl/csr_pkg.sv
package csr_pkg;
    // Register offsets in the data map.
    localparam logic [5:0] CSR_ADR_INDIRECT = 6'h00;
    localparam logic [5:0] CSR_ADR_COUNTER  = 6'h01;
    localparam logic [5:0] CSR_ADR_PC_LOW   = 6'h02;
    localparam logic [5:0] CSR_ADR_STATUS   = 6'h03;
    localparam logic [5:0] CSR_ADR_RSP      = 6'h04;
    localparam logic [5:0] CSR_ADR_SPECIAL_LO = 6'h05;
    localparam logic [5:0] CSR_ADR_SPECIAL_HI = 6'h0f;
    localparam logic [5:0] CSR_ADR_COMMON_LO  = 6'h10;
    localparam logic [5:0] CSR_ADR_COMMON_HI  = 6'h1f;
    localparam logic [5:0] CSR_ADR_BANKED_LO  = 6'h20;
    // Status field positions.
    localparam int CSR_ST_RST  = 7;
    localparam int CSR_ST_IO_SEGMENT_SELECT = 6;
    localparam int CSR_ST_T    = 4;
    localparam int CSR_ST_P    = 3;
    localparam int CSR_ST_Z    = 2;
    localparam int CSR_ST_DC   = 1;
    localparam int CSR_ST_C    = 0;
    // Pointer field positions.
    localparam int CSR_RSP_SPECIAL_BANK_SELECT = 7;
    localparam int CSR_RSP_BANK  = 6;
    // Widths and sizes.
    localparam int CSR_PC_W      = 11;
    localparam int CSR_PAGE_W    = 10;
    localparam int CSR_STACK_D   = 8;
    localparam int CSR_RAM_WORDS = 80;
    // Reset values.
    localparam logic [10:0] CSR_PC_RST     = 11'h000;
    localparam logic [7:0]  CSR_STATUS_RST = 8'h18;
    localparam logic [7:0]  CSR_RSP_RST    = 8'h00;
    localparam logic [7:0]  CSR_CNT_RST    = 8'h00;
    localparam logic [7:0]  CSR_PRE_RST    = 8'h00;
    // One instruction cycle is two oscillator clocks.
    localparam int CSR_CLK_PER_INSTR = 2;

    // Program counter operation requested by the decoder.
    typedef enum logic [2:0] {
        CSR_PC_STEP, CSR_PC_HOLD, CSR_PC_SJMP, CSR_PC_SCALL,
        CSR_PC_LONG_JUMP, CSR_PC_LONG_CALL, CSR_PC_RET
    } csr_pcop_t;

    // Data access request from the datapath.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       add_pc;
        logic [5:0] addr;
        logic [7:0] wdata;
    } csr_dreq_t;

    // Status events from the core.
    typedef struct packed {
        logic flag_wr;
        logic z;
        logic dc;
        logic c;
        logic sleep_instr;
        logic watchdog_clear_instruction_instr;
        logic wdt_timeout;
        logic wake_event;
    } csr_sev_t;
endpackage

// File: rtl/csr_ram.sv
`timescale 1ns/10ps
// Small synchronous data store with registered read data.
module csr_ram #(
    parameter int DEPTH = 80,
    parameter int AW    = 7
) (
    input  wire logic          core_clk_in,
    input  wire logic          we_in,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [7:0]    wdata_in,
    output logic      [7:0]    rdata_out
);
    logic [7:0] mem [DEPTH];    // Storage array, no reset needed.

    // Read first, read data registered for timing.
    always_ff @(posedge core_clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end
endmodule

// File: tb/csr_core_regs_sva.sv
`timescale 1ns/10ps
// Checker for the special register set; it watches only the top-level ports.
module csr_core_regs_sva
    import csr_pkg::*;
#(
    parameter int PC_W    = CSR_PC_W,
    parameter int STACK_D = CSR_STACK_D
) (
    input wire logic               core_clk_in,
    input wire logic               reset_in,
    input wire logic               power_on_in,
    input wire logic               prescaler_wr_in,
    input wire csr_pkg::csr_pcop_t pc_op_in,
    input wire logic [PC_W-1:0]    pc_target_in,
    input wire csr_pkg::csr_dreq_t dreq_in,
    input wire csr_pkg::csr_sev_t  sev_in,
    input wire logic [PC_W-1:0]    pc_out,
    input wire logic               rvalid_out,
    input wire logic [7:0]         status_out,
    input wire logic [7:0]         prescaler_out,
    input wire logic [7:0]         event_counter_out
);
    // One clock domain, so one clocking and one disable serve every check.
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    ////////////////////////////////////////////////////////////////////////////////
    // The first edge after reset must still show the cleared state.
    a_reset_pc_clear: assert property ($fell(reset_in) |-> pc_out == '0 &&
        event_counter_out == 8'h00 && prescaler_out == 8'h00) else $error("reset state wrong");
    a_read_answer: assert property (dreq_in.rd |-> ##2 rvalid_out)
        else $error("read answer late");
    a_status_bit_zero: assert property (!power_on_in |-> status_out[5] == 1'b0)
        else $error("status bit 5 set");
    // Counter writes and select writes both restart the prescaler.
    a_count_write_clear: assert property (dreq_in.wr && dreq_in.addr == CSR_ADR_COUNTER
        |=> prescaler_out == 8'h00) else $error("prescaler kept on counter write");
    a_select_write_clear: assert property (prescaler_wr_in |=> prescaler_out == 8'h00)
        else $error("prescaler kept on select write");
    ////////////////////////////////////////////////////////////////////////////////
    a_sleep_flags: assert property (sev_in.sleep_instr && !sev_in.watchdog_clear_instruction_instr &&
        !sev_in.wdt_timeout && !power_on_in |=> status_out[4:3] == 2'b10)
        else $error("sleep flags wrong");
    a_clear_flags: assert property (sev_in.watchdog_clear_instruction_instr && !sev_in.wdt_timeout
        && !power_on_in |=> status_out[4:3] == 2'b11) else $error("clear flags wrong");
    a_timeout_flag: assert property (sev_in.wdt_timeout && !power_on_in
        |=> !status_out[CSR_ST_T]) else $error("time-out flag kept");
    a_power_on_flags: assert property (power_on_in
        |=> status_out[4:3] == 2'b11 && pc_out == '0) else $error("power-on state wrong");
    a_flag_update: assert property (sev_in.flag_wr && !power_on_in
        |=> status_out[2:0] == {$past(sev_in.z), $past(sev_in.dc), $past(sev_in.c)})
        else $error("arithmetic flags wrong");
    // Long loads span two instruction cycles, so the request stands four clocks.
    a_long_load: assert property ((pc_op_in == CSR_PC_LONG_JUMP)[*4]
        |=> pc_out == $past(pc_target_in)) else $error("long jump target wrong");
    a_short_page: assert property ((pc_op_in == CSR_PC_SJMP)[*2]
        |=> pc_out[9:0] == $past(pc_target_in[9:0]) && pc_out[10] == $past(pc_out[10], 2))
        else $error("short jump page wrong");
endmodule

bind csr_core_regs csr_core_regs_sva #(.PC_W(PC_W), .STACK_D(STACK_D)) u_sva (
    .core_clk_in       (core_clk_in),
    .reset_in          (reset_in),
    .power_on_in       (power_on_in),
    .prescaler_wr_in   (prescaler_wr_in),
    .pc_op_in          (pc_op_in),
    .pc_target_in      (pc_target_in),
    .dreq_in           (dreq_in),
    .sev_in            (sev_in),
    .pc_out            (pc_out),
    .rvalid_out        (rvalid_out),
    .status_out        (status_out),
    .prescaler_out     (prescaler_out),
    .event_counter_out (event_counter_out)
);

// File: tb/csr_core_regs_tb.sv
`timescale 1ns/10ps
module csr_core_regs_tb;
    import csr_pkg::*;
    // One program counter row: request, target, expected counter after it.
    typedef struct packed {csr_pcop_t op; logic [10:0] tgt; logic [10:0] pc;} csr_row_t;
    logic        core_clk_in = 1'b0;
    logic        reset_in    = 1'b1;
    logic        power_on_in = 1'b1;
    logic        pin         = 1'b0;
    logic        esel        = 1'b0;
    logic        src         = 1'b1;
    logic        pwr         = 1'b0;
    csr_pcop_t   op          = CSR_PC_HOLD;
    logic [10:0] tgt         = 11'h000;
    csr_dreq_t   dq          = '0;
    csr_sev_t    sv          = '0;
    logic [10:0] pc;
    logic [7:0]  rdata;
    logic [7:0]  status;
    logic [7:0]  pre;
    logic [7:0]  cnt;
    logic        rvalid;
    logic        strobe;
    logic        iseg;
    logic        special_bank_select;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    // Jumps, calls and returns; the stack must hand back both return points.
    csr_row_t    rows [7] = '{'{CSR_PC_LONG_JUMP, 11'h7f0, 11'h7f0}, '{CSR_PC_STEP, 11'h000, 11'h7f1},
        '{CSR_PC_SJMP, 11'h005, 11'h405}, '{CSR_PC_SCALL, 11'h100, 11'h500},
        '{CSR_PC_LONG_CALL, 11'h023, 11'h023}, '{CSR_PC_RET, 11'h000, 11'h501},
        '{CSR_PC_RET, 11'h000, 11'h406}};

    always #2.5 core_clk_in = ~core_clk_in;

    csr_core_regs dut (
        .core_clk_in (core_clk_in), .reset_in (reset_in), .power_on_in (power_on_in),
        .count_pin_in (pin), .count_edge_select_in (esel), .count_source_pin_in (src),
        .prescaler_wr_in (pwr), .prescaler_sel_in (4'h0), .pc_op_in (op),
        .pc_target_in (tgt), .dreq_in (dq), .sev_in (sv), .pc_out (pc),
        .rdata_out (rdata), .rvalid_out (rvalid), .instr_strobe_out (strobe),
        .special_sel_out (), .special_addr_out (), .special_bank_out (special_bank_select),
        .io_segment_out (iseg), .status_out (status), .prescaler_out (pre),
        .event_counter_out (cnt));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // A wait that runs out counts as a mismatch and ends the run.
    task automatic hang();
        n_mismatch++;
        conclude();
    endtask
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    // Register write; the spare clock keeps two writes from sharing a time step.
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        dq <= '{rd: 1'b0, wr: 1'b1, add_pc: 1'b0, addr: a, wdata: v};
        tick(1);
        dq <= '0;
        tick(1);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        int i;
        dq <= '{rd: 1'b1, wr: 1'b0, add_pc: 1'b0, addr: a, wdata: 8'h00};
        tick(1);
        dq <= '0;
        for (i = 0; i < 4 && rvalid !== 1'b1; i++) begin
            tick(1);
        end
        if (i == 4) begin
            hang();
        end
        v = rdata;
    endtask
    // Program counter writes are only taken on the instruction boundary after a strobe.
    task automatic pcw(input logic add, input logic [7:0] v);
        int i;
        for (i = 0; i < 4 && strobe !== 1'b1; i++) begin
            tick(1);
        end
        if (i == 4) begin
            hang();
        end
        dq <= '{rd: 1'b0, wr: 1'b1, add_pc: add, addr: CSR_ADR_PC_LOW, wdata: v};
        tick(1);
        dq <= '0;
        tick(2);
    endtask
    task automatic event_pulse(input csr_sev_t e, input logic [4:0] exp);
        sv <= e;
        tick(1);
        sv <= '0;
        tick(2);
        check("status", {6'h00, status[4:0]}, {6'h00, exp});
    endtask
    task automatic edges(input int n);
        repeat (n) begin
            pin <= 1'b1;
            tick(4);
            pin <= 1'b0;
            tick(4);
        end
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v;
        tick(4);
        reset_in <= 1'b0;
        tick(1);
        power_on_in <= 1'b0;
        tick(1);
        rd(CSR_ADR_STATUS, v);
        check("status after power-on", {3'h0, v}, 11'h018);
        foreach (rows[k]) begin
            op <= rows[k].op;
            tgt <= rows[k].tgt;
            tick((rows[k].op inside {CSR_PC_LONG_JUMP, CSR_PC_LONG_CALL}) ? 4 : 2);
            op <= CSR_PC_HOLD;
            tick(2);
            check("pc", pc, rows[k].pc);
        end
        pcw(1'b0, 8'hff);
        check("pc after move", pc, 11'h4ff);
        pcw(1'b1, 8'h03);
        check("pc after add", pc, 11'h502);
        $display("test program counter done");
        // Indirect access through the pointer, common and banked bytes.
        wr(CSR_ADR_RSP, 8'h10);
        rd(CSR_ADR_RSP, v);
        check("pointer", {3'h0, v}, 11'h010);
        wr(CSR_ADR_INDIRECT, 8'h5a);
        rd(6'h10, v);
        check("common via port", {3'h0, v}, 11'h05a);
        wr(CSR_ADR_RSP, 8'h60);
        wr(6'h20, 8'h22);
        wr(CSR_ADR_RSP, 8'h20);
        wr(6'h20, 8'h11);
        rd(CSR_ADR_INDIRECT, v);
        check("bank 0 via port", {3'h0, v}, 11'h011);
        wr(CSR_ADR_RSP, 8'h60);
        rd(CSR_ADR_INDIRECT, v);
        check("bank 1 via port", {3'h0, v}, 11'h022);
        // The special bank output is registered one clock behind the pointer.
        wr(CSR_ADR_RSP, 8'he0);
        tick(1);
        check("special bank", {10'h000, special_bank_select}, 11'h001);
        $display("test data map done");
        event_pulse('{sleep_instr: 1'b1, default: 1'b0}, 5'h10);
        event_pulse('{wdt_timeout: 1'b1, default: 1'b0}, 5'h00);
        event_pulse('{watchdog_clear_instruction_instr: 1'b1, default: 1'b0}, 5'h18);
        event_pulse('{flag_wr: 1'b1, z: 1'b1, c: 1'b1, default: 1'b0}, 5'h1d);
        wr(CSR_ADR_STATUS, 8'hff);
        rd(CSR_ADR_STATUS, v);
        check("status write", {3'h0, v}, 11'h05f);
        check("io segment", {10'h000, iseg}, 11'h001);
        $display("test status done");
        // Pin edges of either polarity, then instruction cycles.
        wr(CSR_ADR_COUNTER, 8'h10);
        check("prescaler on write", {3'h0, pre}, 11'h000);
        edges(3);
        check("rising count", {3'h0, cnt}, 11'h013);
        esel <= 1'b1;
        edges(2);
        check("falling count", {3'h0, cnt}, 11'h015);
        pwr <= 1'b1;
        tick(1);
        pwr <= 1'b0;
        tick(1);
        check("prescaler on select", {3'h0, pre}, 11'h000);
        wr(CSR_ADR_COUNTER, 8'h20);
        src <= 1'b0;
        tick(10);
        src <= 1'b1;
        tick(1);
        check("cycle count", {3'h0, cnt}, 11'h025);
        $display("test counter done");
        // A wake-up reset in mid-run.
        sv <= '{wake_event: 1'b1, default: 1'b0};
        reset_in <= 1'b1;
        tick(2);
        reset_in <= 1'b0;
        sv <= '0;
        tick(1);
        check("pc after reset", pc, 11'h000);
        check("reset type", {10'h000, status[7]}, 11'h001);
        check("counter after reset", {3'h0, cnt}, 11'h000);
        $display("test reset done");
        conclude();
    end
endmodule
